// ### logic/cmcs_first.sv
// Purpose: lowest-numbered set request finder
// Assumes: request bit 1 is highest priority
// Notes: purely combinational
`timescale 1ns/100ps
module cmcs_first #(
   parameter int unsigned N = 15,
   parameter int unsigned IW = 4
) (
   input wire logic [N:1] req_in,
   output logic found_out,
   output logic [IW-1:0] idx_out
);
   always_comb begin
      found_out = 1'h0;
      idx_out = '0;
      // walk downward so the lowest set bit is the last one written
      for (int i = N; i >= 1; i--) begin
         if (req_in[i]) begin
            found_out = 1'h1;
            idx_out = IW'(i);
         end
      end
   end
endmodule

// ### logic/cmcs_pkg.sv
// Purpose: shared constants for the message-center scheduler
// Assumes: 15 centers, 29-bit identifiers, word-indexed register port
// Notes: a center's control word sits at its own number, its id at 0x10 plus it
package cmcs_pkg;
   localparam int unsigned NUM_CENTERS = 15;
   localparam int unsigned ID_W = 29;
   localparam int unsigned DLC_W = 4;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CTL_W = 16;

   localparam logic [5:0] STATUS_OFS = 6'h00;
   localparam logic [5:0] ID_BASE = 6'h10;
   localparam logic [5:0] GMASK_OFS = 6'h20;
   localparam logic [5:0] C15MASK_OFS = 6'h21;

   // control word fields
   localparam int unsigned CB_DIR = 0;
   localparam int unsigned CB_INH = 1;
   localparam int unsigned CB_DU = 2;
   localparam int unsigned CB_RDY = 3;
   localparam int unsigned CB_TREQ = 4;
   localparam int unsigned CB_EXT = 5;
   localparam int unsigned CB_OVR = 6;
   localparam int unsigned CB_TIE = 7;
   localparam int unsigned CB_RIE = 8;
   localparam int unsigned CB_IRQ = 9;
   localparam int unsigned CB_MSK = 10;
   localparam int unsigned CB_XID = 11;
   localparam int unsigned CB_DLC = 12;

   // status word fields
   localparam int unsigned SB_TXS = 0;
   localparam int unsigned SB_RXS = 1;
   localparam int unsigned SB_OWE = 2;
   localparam int unsigned SB_ABD = 3;
   localparam int unsigned SB_CUR = 4;

   localparam logic [15:0] CTL_RST = 16'h0000;
   localparam logic [28:0] ID_RST = 29'h0000000;
   localparam logic [28:0] MASK_RST = 29'h1FFFFFFF;
   localparam logic [28:0] STD_ID_MASK = 29'h00007FF;
   localparam logic FLAG_RST = 1'h0;

   typedef enum logic [0:0] {
      CMCS_SCAN = 1'h0,
      CMCS_SEND = 1'h1
   } cmcs_state_t;
endpackage

// ### logic/cmcs_sched.sv
// Purpose: CAN message-center transmit scan, receive acceptance, remote replies
// Assumes: frame engine on the same clock; tx_done_in pulses once per attempt
// Notes: data bytes live in the frame engine; this block steers control bits
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
// Notes on behaviour
// - transmit scan picks the lowest fully enabled center, transmit or remote-request.
// - selected center is sent; success clears its transmit request.
// - after any outcome the scan restarts from center 1.
// - data frames go to the first matching receive center only.
// - unread centers are overwritten by data frames only with overwrite enable, setting overrun.
// - center 15 is receive-only with one shadow slot; others do everything.
// - center 15 overrun reports shadow overwrites; read flags are live values.
// - shadow moves into center 15 once its updated and request flags clear.
// - while either is set, new frames fill shadow if overwrite enabled, else drop.
// - receive centers with ready and request send remote requests; inhibit ignored.
// - sent remote request clears request, sets tx success, maybe interrupt.
// - no remote request sending or handling while autobaud is on.
// - remote request matches ready centers, stores count, sets request and rx flags.
// - stored remote request interrupts only with receive interrupt enable.
// - transmit center hit sets request flags, replies when fully enabled.
// - reply sent sets tx success, clears both requests, maybe interrupts.
// - inhibited center still takes request and count but withholds reply.
// - reply waits for updated and no inhibit, then clears external request.
// - receive center hit stores count and external request, no transmit.
// - with masking only mask-one id bits are compared.
module cmcs_sched #(
   parameter int unsigned NC = cmcs_pkg::NUM_CENTERS
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [5:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [31:0] rd_data_out,
   output logic tx_req_out,
   output logic [3:0] tx_center_out,
   output logic tx_remote_out,
   output logic [28:0] tx_id_out,
   output logic tx_ext_out,
   output logic [3:0] tx_dlc_out,
   input wire logic tx_done_in,
   input wire logic tx_ok_in,
   input wire logic rx_valid_in,
   input wire logic [28:0] rx_id_in,
   input wire logic rx_ext_in,
   input wire logic rx_remote_in,
   input wire logic [3:0] rx_dlc_in,
   output logic rx_store_out,
   output logic [3:0] rx_center_out,
   output logic rx_shadow_out,
   output logic shadow_move_out,
   output logic [NC:1] center_irq_out
);
   logic [15:0] ctl_q [1:NC];
   logic [28:0] id_q [1:NC];
   logic [NC:1] du_v, ext_v, treq_v, tx_elig, rx_cand;
   logic tx_success_reg, rx_success_reg, overwrite_enable_reg, autobaud_reg;
   logic [28:0] gmask_reg, c15mask_reg;
   logic sh_valid_reg, sh_ext_reg, sh_remote_reg;
   logic [28:0] sh_id_reg;
   logic [3:0] sh_dlc_reg;
   cmcs_pkg::cmcs_state_t state_reg;
   logic tx_found, rx_found;
   logic [3:0] tx_idx, rx_idx;
   logic c15_busy, rx_hit, rx_drop, rx_to_shadow, rx_direct, move_now, tx_ok_ev;
   logic [31:0] rd_word;

   function automatic logic [NC:1] below(input logic [3:0] idx);
      logic [NC:1] m;
      m = '0;
      for (int k = 1; k <= NC; k++) begin
         if (4'(k) < idx) begin
            m[k] = 1'h1;
         end
      end
      return m;
   endfunction

   cmcs_first #(.N(NC), .IW(4)) u_tx_scan (
      .req_in(tx_elig),
      .found_out(tx_found),
      .idx_out(tx_idx)
   );

   cmcs_first #(.N(NC), .IW(4)) u_rx_scan (
      .req_in(rx_cand),
      .found_out(rx_found),
      .idx_out(rx_idx)
   );

   // shadow occupancy counts as busy so a live frame never jumps the queue
   assign c15_busy = du_v[NC] | ext_v[NC] | sh_valid_reg;
   assign rx_hit = rx_valid_in & rx_found;
   assign rx_drop = rx_hit & (rx_idx == 4'(NC)) & c15_busy & ~overwrite_enable_reg;
   assign rx_to_shadow = rx_hit & (rx_idx == 4'(NC)) & c15_busy & overwrite_enable_reg;
   assign rx_direct = rx_hit & ~rx_drop & ~rx_to_shadow;
   assign move_now = sh_valid_reg & ~du_v[NC] & ~ext_v[NC];
   assign tx_ok_ev = (state_reg == cmcs_pkg::CMCS_SEND) & tx_done_in & tx_ok_in;

   for (genvar g = 1; g <= NC; g++) begin : g_ctr
      localparam bit LAST = (g == NC);
      localparam logic [5:0] A_CTL = 6'(g);
      localparam logic [5:0] A_ID = cmcs_pkg::ID_BASE | 6'(g);
      logic [15:0] ctl_reg, ctl_next;
      logic [28:0] id_reg, effm, wmask;
      logic hit_me, sent_me;

      assign ctl_q[g] = ctl_reg;
      assign id_q[g] = id_reg;
      assign du_v[g] = ctl_reg[cmcs_pkg::CB_DU];
      assign ext_v[g] = ctl_reg[cmcs_pkg::CB_EXT];
      assign treq_v[g] = ctl_reg[cmcs_pkg::CB_TREQ];
      assign center_irq_out[g] = ctl_reg[cmcs_pkg::CB_IRQ];

      always_comb begin
         // mask-zero bits always match; center 15 also ands its own mask
         effm = cmcs_pkg::MASK_RST;
         if (ctl_reg[cmcs_pkg::CB_MSK]) begin
            effm = LAST ? (gmask_reg & c15mask_reg) : gmask_reg;
         end
         wmask = ctl_reg[cmcs_pkg::CB_XID] ? cmcs_pkg::MASK_RST : cmcs_pkg::STD_ID_MASK;
      end

      // transmit eligibility; the other party keeps ready low while editing
      always_comb begin
         tx_elig[g] = 1'h0;
         if (!LAST && ctl_reg[cmcs_pkg::CB_RDY] && ctl_reg[cmcs_pkg::CB_TREQ]) begin
            if (ctl_reg[cmcs_pkg::CB_DIR]) begin
               tx_elig[g] = ~ctl_reg[cmcs_pkg::CB_INH] & ctl_reg[cmcs_pkg::CB_DU]
                            & ~(ctl_reg[cmcs_pkg::CB_EXT] & autobaud_reg);
            end else begin
               tx_elig[g] = ~autobaud_reg;
            end
         end
      end

      always_comb begin
         rx_cand[g] = ctl_reg[cmcs_pkg::CB_RDY]
                      & (ctl_reg[cmcs_pkg::CB_XID] == rx_ext_in)
                      & ~|((rx_id_in ^ id_reg) & effm & wmask);
         if (rx_remote_in) begin
            rx_cand[g] = rx_cand[g] & ~autobaud_reg;
         end else begin
            rx_cand[g] = rx_cand[g] & ~ctl_reg[cmcs_pkg::CB_DIR]
                         & (LAST | ~ctl_reg[cmcs_pkg::CB_DU] | overwrite_enable_reg);
         end
      end

      assign hit_me = rx_direct & (rx_idx == 4'(g));
      assign sent_me = tx_ok_ev & (tx_center_out == 4'(g));

      always_comb begin
         ctl_next = ctl_reg;
         if (wr_en_in && addr_in == A_CTL) begin
            ctl_next = wr_data_in[15:0];
         end
         if (sent_me) begin
            ctl_next[cmcs_pkg::CB_TREQ] = 1'h0;
            if (ctl_reg[cmcs_pkg::CB_DIR]) begin
               ctl_next[cmcs_pkg::CB_EXT] = 1'h0;
            end
            if (ctl_reg[cmcs_pkg::CB_TIE]) begin
               ctl_next[cmcs_pkg::CB_IRQ] = 1'h1;
            end
         end
         // hardware sets come last so they beat a software clear
         if (hit_me) begin
            ctl_next[cmcs_pkg::CB_DLC +: 4] = rx_dlc_in;
            if (ctl_reg[cmcs_pkg::CB_RIE]) begin
               ctl_next[cmcs_pkg::CB_IRQ] = 1'h1;
            end
            if (rx_remote_in) begin
               ctl_next[cmcs_pkg::CB_EXT] = 1'h1;
               if (ctl_reg[cmcs_pkg::CB_DIR]) begin
                  ctl_next[cmcs_pkg::CB_TREQ] = 1'h1;
               end else begin
                  ctl_next[cmcs_pkg::CB_DU] = 1'h1;
               end
            end else begin
               ctl_next[cmcs_pkg::CB_DU] = 1'h1;
               if (ctl_reg[cmcs_pkg::CB_DU] && !LAST) begin
                  ctl_next[cmcs_pkg::CB_OVR] = 1'h1;
               end
            end
         end
         if (LAST) begin
            if (move_now) begin
               ctl_next[cmcs_pkg::CB_DU] = 1'h1;
               ctl_next[cmcs_pkg::CB_EXT] = sh_remote_reg;
               ctl_next[cmcs_pkg::CB_DLC +: 4] = sh_dlc_reg;
               ctl_next[cmcs_pkg::CB_XID] = sh_ext_reg;
               ctl_next[cmcs_pkg::CB_IRQ] = ctl_next[cmcs_pkg::CB_IRQ] | ctl_reg[cmcs_pkg::CB_RIE];
            end
            if (rx_to_shadow && sh_valid_reg && !move_now) begin
               ctl_next[cmcs_pkg::CB_OVR] = 1'h1;
            end
            ctl_next[cmcs_pkg::CB_DIR] = 1'h0;
            ctl_next[cmcs_pkg::CB_TREQ] = 1'h0;
         end
      end

      always_ff @(posedge clk_in or posedge rst_in) begin
         if (rst_in) begin
            ctl_reg <= cmcs_pkg::CTL_RST;
         end else begin
            ctl_reg <= ctl_next;
         end
      end

      always_ff @(posedge clk_in or posedge rst_in) begin
         if (rst_in) begin
            id_reg <= cmcs_pkg::ID_RST;
         end else if (hit_me) begin
            id_reg <= rx_id_in;
         end else if (LAST && move_now) begin
            id_reg <= sh_id_reg;
         end else if (wr_en_in && addr_in == A_ID) begin
            id_reg <= wr_data_in[28:0];
         end
      end
   end

   // global flags: software writes the value, hardware sets win
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_success_reg <= cmcs_pkg::FLAG_RST;
         rx_success_reg <= cmcs_pkg::FLAG_RST;
         overwrite_enable_reg <= cmcs_pkg::FLAG_RST;
         autobaud_reg <= cmcs_pkg::FLAG_RST;
      end else begin
         if (wr_en_in && addr_in == cmcs_pkg::STATUS_OFS) begin
            tx_success_reg <= wr_data_in[cmcs_pkg::SB_TXS] | tx_ok_ev;
            rx_success_reg <= wr_data_in[cmcs_pkg::SB_RXS] | rx_direct | rx_to_shadow;
            overwrite_enable_reg <= wr_data_in[cmcs_pkg::SB_OWE];
            autobaud_reg <= wr_data_in[cmcs_pkg::SB_ABD];
         end else begin
            if (tx_ok_ev) begin
               tx_success_reg <= 1'h1;
            end
            if (rx_direct || rx_to_shadow) begin
               rx_success_reg <= 1'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         gmask_reg <= cmcs_pkg::MASK_RST;
         c15mask_reg <= cmcs_pkg::MASK_RST;
      end else if (wr_en_in) begin
         if (addr_in == cmcs_pkg::GMASK_OFS) begin
            gmask_reg <= wr_data_in[28:0];
         end
         if (addr_in == cmcs_pkg::C15MASK_OFS) begin
            c15mask_reg <= wr_data_in[28:0];
         end
      end
   end

   // one-slot shadow; a frame arriving during the move still lands here
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sh_valid_reg <= 1'h0;
         sh_id_reg <= cmcs_pkg::ID_RST;
         sh_ext_reg <= 1'h0;
         sh_remote_reg <= 1'h0;
         sh_dlc_reg <= 4'h0;
      end else begin
         if (rx_to_shadow) begin
            sh_valid_reg <= 1'h1;
            sh_id_reg <= rx_id_in;
            sh_ext_reg <= rx_ext_in;
            sh_remote_reg <= rx_remote_in;
            sh_dlc_reg <= rx_dlc_in;
         end else if (move_now) begin
            sh_valid_reg <= 1'h0;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_store_out <= 1'h0;
         rx_center_out <= 4'h0;
         rx_shadow_out <= 1'h0;
         shadow_move_out <= 1'h0;
      end else begin
         rx_store_out <= rx_direct | rx_to_shadow;
         rx_shadow_out <= rx_to_shadow;
         shadow_move_out <= move_now;
         if (rx_direct || rx_to_shadow) begin
            rx_center_out <= rx_idx;
         end
      end
   end

   // the scan only runs from the idle state, so every outcome restarts at 1
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= cmcs_pkg::CMCS_SCAN;
         tx_req_out <= 1'h0;
         tx_center_out <= 4'h0;
         tx_remote_out <= 1'h0;
         tx_id_out <= cmcs_pkg::ID_RST;
         tx_ext_out <= 1'h0;
         tx_dlc_out <= 4'h0;
      end else begin
         unique case (state_reg)
            cmcs_pkg::CMCS_SCAN: begin
               if (tx_found) begin
                  state_reg <= cmcs_pkg::CMCS_SEND;
                  tx_req_out <= 1'h1;
                  tx_center_out <= tx_idx;
                  tx_remote_out <= ~ctl_q[tx_idx][cmcs_pkg::CB_DIR];
                  tx_id_out <= id_q[tx_idx];
                  tx_ext_out <= ctl_q[tx_idx][cmcs_pkg::CB_XID];
                  tx_dlc_out <= ctl_q[tx_idx][cmcs_pkg::CB_DLC +: 4];
               end
            end
            cmcs_pkg::CMCS_SEND: begin
               if (tx_done_in) begin
                  state_reg <= cmcs_pkg::CMCS_SCAN;
                  tx_req_out <= 1'h0;
               end
            end
         endcase
      end
   end

   always_comb begin
      rd_word = 32'h00000000;
      if (addr_in == cmcs_pkg::STATUS_OFS) begin
         rd_word[cmcs_pkg::SB_TXS] = tx_success_reg;
         rd_word[cmcs_pkg::SB_RXS] = rx_success_reg;
         rd_word[cmcs_pkg::SB_OWE] = overwrite_enable_reg;
         rd_word[cmcs_pkg::SB_ABD] = autobaud_reg;
         rd_word[cmcs_pkg::SB_CUR +: 4] = tx_center_out;
      end
      if (addr_in == cmcs_pkg::GMASK_OFS) begin
         rd_word[28:0] = gmask_reg;
      end
      if (addr_in == cmcs_pkg::C15MASK_OFS) begin
         rd_word[28:0] = c15mask_reg;
      end
      for (int k = 1; k <= NC; k++) begin
         if (addr_in == 6'(k)) begin
            rd_word[15:0] = ctl_q[k];
         end
         if (addr_in == (cmcs_pkg::ID_BASE | 6'(k))) begin
            rd_word[28:0] = id_q[k];
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_out <= 32'h00000000;
      end else begin
         rd_data_out <= rd_en_in ? rd_word : 32'h00000000;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_send_ok;
      (state_reg == cmcs_pkg::CMCS_SEND) && tx_done_in && tx_ok_in;
   endsequence

   sequence s_shadow_free;
      sh_valid_reg && !du_v[NC] && !ext_v[NC];
   endsequence

   a_tx_pick_lowest: assert property (
      $rose(tx_req_out) |-> ($past(tx_elig) & below(tx_center_out)) == '0)
      else $error("transmit scan skipped a lower eligible center");
   a_tx_clear_req: assert property (
      s_send_ok |=> !treq_v[tx_center_out])
      else $error("transmit request not cleared after success");
   a_tx_rescan: assert property (
      (state_reg == cmcs_pkg::CMCS_SEND) && tx_done_in |=> !tx_req_out ##0
      (state_reg == cmcs_pkg::CMCS_SCAN))
      else $error("scan did not restart after an attempt");
   a_rx_first_hit: assert property (
      rx_store_out |-> ($past(rx_cand) & below(rx_center_out)) == '0)
      else $error("frame stored past a lower matching center");
   a_rx_no_overwrite: assert property (
      rx_store_out && !rx_shadow_out && !$past(overwrite_enable_reg)
      && !$past(rx_remote_in) |->
      (($past(du_v) >> (rx_center_out - 4'h1)) & NC'(1)) == '0)
      else $error("unread center overwritten with overwrite disabled");
   a_c15_no_tx: assert property (
      tx_req_out |-> tx_center_out != 4'(NC))
      else $error("center 15 selected for transmit");
   a_shadow_move: assert property (
      s_shadow_free |=> shadow_move_out && du_v[NC])
      else $error("shadow not moved into center 15");
   a_shadow_hold: assert property (
      sh_valid_reg && (du_v[NC] || ext_v[NC]) |=> sh_valid_reg && !shadow_move_out)
      else $error("shadow moved while center 15 busy");
   a_tx_success: assert property (
      s_send_ok |=> tx_success_reg [*2])
      else $error("successful transmit flag not set");
   a_abd_no_remote: assert property (
      $rose(tx_req_out) && $past(autobaud_reg) |-> !tx_remote_out)
      else $error("remote request sent during autobaud");
endmodule

// ### tb/cmcs_node_model.sv
// Purpose: frame engine and remote node stand-in for the transmit link
// Assumes: one attempt per rise of tx_req_in, judged by ok_in
// Notes: tx_ok_out shows the inverse level outside the done pulse
`timescale 1ns/100ps
module cmcs_node_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic tx_req_in,
   input wire logic ok_in,
   input wire logic [7:0] delay_in,
   output logic tx_done_out,
   output logic tx_ok_out
);
   logic [7:0] cnt_reg;
   logic sent_reg;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_reg <= 8'h00;
         sent_reg <= 1'h0;
         tx_done_out <= 1'h0;
         tx_ok_out <= 1'h0;
      end else begin
         tx_done_out <= 1'h0;
         tx_ok_out <= ~ok_in;
         if (!tx_req_in) begin
            cnt_reg <= 8'h00;
            sent_reg <= 1'h0;
         end else if (!sent_reg) begin
            cnt_reg <= cnt_reg + 8'h01;
            // one answer per attempt; a zero delay answers in the first cycle
            if (cnt_reg == delay_in) begin
               tx_done_out <= 1'h1;
               tx_ok_out <= ok_in;
               sent_reg <= 1'h1;
            end
         end
      end
   end
endmodule

// ### tb/cmcs_sched_tb_top.sv
// Purpose: self-checking bench for the message-center scheduler
// Assumes: register port with read data one cycle after the strobe
// Notes: standard ids only, so rx_ext_in stays low
`timescale 1ns/100ps
module cmcs_sched_tb_top;
   logic clk, rst, wr_en, rd_en, rx_valid, rx_remote, ok;
   logic tx_req, tx_remote, tx_ext, tx_done, tx_ok, rx_store, rx_shadow, shadow_move;
   logic [5:0] addr;
   logic [31:0] wdata, rdata;
   logic [28:0] rx_id, tx_id;
   logic [3:0] rx_dlc, tx_center, tx_dlc, rx_center;
   logic [7:0] delay;
   logic [15:1] irq;
   int failures = 0;
   int tests_run = 0;

   cmcs_sched DUT (.clk_in(clk), .rst_in(rst), .addr_in(addr), .wr_data_in(wdata),
      .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata), .tx_req_out(tx_req),
      .tx_center_out(tx_center), .tx_remote_out(tx_remote), .tx_id_out(tx_id),
      .tx_ext_out(tx_ext), .tx_dlc_out(tx_dlc), .tx_done_in(tx_done), .tx_ok_in(tx_ok),
      .rx_valid_in(rx_valid), .rx_id_in(rx_id), .rx_ext_in(1'h0), .rx_remote_in(rx_remote),
      .rx_dlc_in(rx_dlc), .rx_store_out(rx_store), .rx_center_out(rx_center),
      .rx_shadow_out(rx_shadow), .shadow_move_out(shadow_move), .center_irq_out(irq));
   cmcs_node_model node (.clk_in(clk), .rst_in(rst), .tx_req_in(tx_req), .ok_in(ok),
      .delay_in(delay), .tx_done_out(tx_done), .tx_ok_out(tx_ok));

   task automatic finish_test();
      if (failures == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_en <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'h0;
      wdata <= ~d;
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd_en <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'h0;
      #1;
      chk(rdata, exp, "read");
   endtask

   // c of zero means the frame must be dropped
   task automatic rx(input logic [28:0] id, input logic rem, input logic [3:0] dlc,
                     input logic [3:0] c, input logic sh);
      @(posedge clk);
      rx_valid <= 1'h1;
      rx_id <= id;
      rx_remote <= rem;
      rx_dlc <= dlc;
      @(posedge clk);
      rx_valid <= 1'h0;
      rx_id <= ~id;
      rx_dlc <= ~dlc;
      #1;
      chk({31'h0, rx_store}, {31'h0, c != 4'h0}, "store");
      if (c != 4'h0) begin
         chk({28'h0, rx_center}, {28'h0, c}, "rx center");
         chk({31'h0, rx_shadow}, {31'h0, sh}, "shadow slot");
      end
   endtask

   task automatic wait_for(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 200) begin
            chk(32'h0, 32'h1, "timeout");
            finish_test();
         end
      end
   endtask

   task automatic tx_chk(input logic [3:0] c, input logic rem);
      wait_for(tx_req, 1'h1);
      chk({28'h0, tx_center}, {28'h0, c}, "tx center");
      chk({31'h0, tx_remote}, {31'h0, rem}, "tx kind");
      chk({31'h0, tx_ext}, 32'h0, "tx ext");
   endtask

   task automatic no_tx(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         chk({31'h0, tx_req}, 32'h0, "idle");
      end
   endtask

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   initial begin
      rst = 1'h1;
      wr_en = 1'h0;
      rd_en = 1'h0;
      addr = 6'h00;
      wdata = 32'h00000000;
      rx_valid = 1'h0;
      rx_remote = 1'h0;
      rx_id = 29'h0000000;
      rx_dlc = 4'h0;
      ok = 1'h0;
      delay = 8'h08;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      rd(6'h01, 32'h00000000);
      rd(6'h20, 32'h1FFFFFFF);
      wr(6'h30, 32'hFFFFFFFF);
      rd(6'h30, 32'h00000000);
      // a failed attempt must rescan and find the newly enabled center 2
      wr(6'h02, 32'h00000095);
      wr(6'h03, 32'h0000001D);
      tx_chk(4'h3, 1'h0);
      wr(6'h02, 32'h0000009D);
      wait_for(tx_req, 1'h0);
      ok <= 1'h1;
      tx_chk(4'h2, 1'h0);
      wait_for(tx_req, 1'h0);
      delay <= 8'h00;
      tx_chk(4'h3, 1'h0);
      wait_for(tx_req, 1'h0);
      rd(6'h02, 32'h0000028D);
      rd(6'h03, 32'h0000000D);
      rd(6'h00, 32'h00000031);
      // inhibited data center skipped, remote request held off during autobaud
      wr(6'h00, 32'h00000008);
      wr(6'h04, 32'h0000001F);
      wr(6'h05, 32'h0000001A);
      no_tx(12);
      wr(6'h00, 32'h00000000);
      tx_chk(4'h5, 1'h1);
      wait_for(tx_req, 1'h0);
      rd(6'h05, 32'h0000000A);
      rd(6'h00, 32'h00000051);
      // data reception, overwrite control and masking
      wr(6'h16, 32'h00000123);
      wr(6'h06, 32'h00000008);
      rx(29'h123, 1'h0, 4'h3, 4'h6, 1'h0);
      rd(6'h06, 32'h0000300C);
      rx(29'h123, 1'h0, 4'h5, 4'h0, 1'h0);
      wr(6'h00, 32'h00000004);
      rx(29'h123, 1'h0, 4'h5, 4'h6, 1'h0);
      rd(6'h06, 32'h0000504C);
      wr(6'h20, 32'h0000000F);
      wr(6'h18, 32'h000000F0);
      wr(6'h08, 32'h00000408);
      rx(29'h7F0, 1'h0, 4'h1, 4'h8, 1'h0);
      // remote request to an inhibited reply center, then release
      wr(6'h17, 32'h00000055);
      wr(6'h07, 32'h0000008F);
      rx(29'h055, 1'h1, 4'h2, 4'h7, 1'h0);
      rd(6'h07, 32'h000020BF);
      no_tx(8);
      wr(6'h07, 32'h000020BD);
      tx_chk(4'h7, 1'h0);
      chk({28'h0, tx_dlc}, 32'h00000002, "reply count");
      chk({3'h0, tx_id}, 32'h00000055, "reply id");
      wait_for(tx_req, 1'h0);
      rd(6'h07, 32'h0000228D);
      chk({16'h0, irq, 1'h0}, 32'h00000084, "irq");
      wr(6'h06, 32'h0000514C);
      rx(29'h123, 1'h1, 4'h4, 4'h6, 1'h0);
      rd(6'h06, 32'h0000436C);
      no_tx(4);
      rd(6'h00, 32'h00000077);
      // center 15 direct store, shadow fill, move once read flags clear
      wr(6'h1F, 32'h000003AA);
      wr(6'h0F, 32'h00000019);
      rd(6'h0F, 32'h00000008);
      rx(29'h3AA, 1'h0, 4'h1, 4'hF, 1'h0);
      rx(29'h3AA, 1'h0, 4'h2, 4'hF, 1'h1);
      rx(29'h3AA, 1'h0, 4'h3, 4'hF, 1'h1);
      rd(6'h0F, 32'h0000104C);
      wr(6'h0F, 32'h00000008);
      wait_for(shadow_move, 1'h1);
      rd(6'h0F, 32'h0000300C);
      finish_test();
   end
endmodule
